//--- design/dtpos_top.sv
// Device-side debug TAP with 2-wire link, CPU feed and fast data path
`timescale 1ns/1ps
module dtpos_top import dtpos_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_pgec,
    input wire logic i_pged,
    output logic o_pged,
    output logic o_pged_oe,
    input wire logic i_two_phase,
    input wire logic i_cpu_access,
    input wire logic i_cpu_fast_wr,
    input wire logic [31:0] i_cpu_fast_data,
    output dtpos_cpu_req_t o_cpu_req,
    output logic [31:0] o_fast_word,
    output logic o_fast_valid,
    output logic o_processor_access_flag
);
    logic rst_meta_ff, rst_n;
    logic clk_meta_ff, clk_sync_ff, clk_prev_ff;
    logic dat_meta_ff, dat_sync_ff;
    logic fall, step, force_rst, tdo_c;
    dtpos_bits_t bits;
    dtpos_tap_t state_ff, nxt_state;
    logic [4:0] ir_ff, nxt_ir;
    logic [31:0] sr_ff, nxt_sr;
    logic [31:0] ctrl_ff, nxt_ctrl;
    logic [31:0] data_ff, nxt_data;
    logic [31:0] fast_ff, nxt_fast;
    logic [31:0] fword_ff, nxt_fword;
    logic processor_access_flag_ff, nxt_processor_access_flag;
    logic exec_ff, nxt_exec;
    logic fvalid_ff, nxt_fvalid;

    ////////////////////////////////////////////////////////////////////////
    function automatic dtpos_tap_t tap_next(input dtpos_tap_t s,
                                            input logic tms);
        dtpos_tap_t n;
        n = s;
        unique case (s)
            ST_RESET: n = tms ? ST_RESET : ST_IDLE;
            ST_IDLE: n = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: n = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: n = tms ? ST_EX1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: n = tms ? ST_EX1_DR : ST_SHIFT_DR;
            ST_EX1_DR: n = tms ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: n = tms ? ST_EX2_DR : ST_PAUSE_DR;
            ST_EX2_DR: n = tms ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: n = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: n = tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: n = tms ? ST_EX1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: n = tms ? ST_EX1_IR : ST_SHIFT_IR;
            ST_EX1_IR: n = tms ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: n = tms ? ST_EX2_IR : ST_PAUSE_IR;
            ST_EX2_IR: n = tms ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: n = tms ? ST_SEL_DR : ST_IDLE;
        endcase
        return n;
    endfunction

    // Unknown commands fall back to the one-bit bypass path
    function automatic logic [5:0] dr_len(input logic [4:0] ir);
        logic [5:0] l;
        l = LEN_BYPASS;
        if (ir == CMD_DATA || ir == CMD_CONTROL || ir == CMD_FAST) begin
            l = LEN_WORD;
        end
        return l;
    endfunction

    function automatic logic [31:0] shift_in(input logic [31:0] sr,
                                             input logic tdi,
                                             input logic [5:0] len);
        logic [31:0] r;
        r = sr >> 1;
        r[5'(len - 6'h01)] = tdi;
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers; the link clock is only sampled
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_ff <= 1'b0;
            rst_n <= 1'b0;
        end else if (i_ce) begin
            rst_meta_ff <= 1'b1;
            rst_n <= rst_meta_ff;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_meta_ff <= 1'b0;
            clk_sync_ff <= 1'b0;
            clk_prev_ff <= 1'b0;
            dat_meta_ff <= 1'b0;
            dat_sync_ff <= 1'b0;
        end else if (i_ce) begin
            clk_meta_ff <= i_pgec;
            clk_sync_ff <= clk_meta_ff;
            clk_prev_ff <= clk_sync_ff;
            dat_meta_ff <= i_pged;
            dat_sync_ff <= dat_meta_ff;
        end
    end

    // Pin bits are sampled on the falling link clock edge
    assign fall = clk_prev_ff & ~clk_sync_ff;

    dtpos_phy u_phy (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_ce(i_ce),
        .i_fall(fall),
        .i_dat(dat_sync_ff),
        .i_two_phase(i_two_phase),
        .i_tdo(tdo_c),
        .o_step(step),
        .o_bits(bits),
        .o_force_reset(force_rst),
        .o_pged(o_pged),
        .o_pged_oe(o_pged_oe)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        tdo_c = 1'b0;
        if (state_ff == ST_CAP_DR && ir_ff == CMD_FAST) begin
            tdo_c = processor_access_flag_ff;
        end else if (state_ff == ST_SHIFT_DR || state_ff == ST_SHIFT_IR) begin
            tdo_c = sr_ff[0];
        end
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_ir = ir_ff;
        nxt_sr = sr_ff;
        nxt_ctrl = ctrl_ff;
        nxt_data = data_ff;
        nxt_fast = fast_ff;
        nxt_fword = fword_ff;
        nxt_processor_access_flag = processor_access_flag_ff;
        nxt_exec = 1'b0;
        nxt_fvalid = 1'b0;
        if (i_cpu_fast_wr) begin
            nxt_fast = i_cpu_fast_data;
        end
        if (step) begin
            nxt_state = tap_next(state_ff, bits.tms);
            unique case (state_ff)
                ST_RESET: nxt_ir = CMD_BYPASS;
                ST_CAP_IR: nxt_sr = {27'h0000000, IR_CAPTURE};
                ST_CAP_DR: begin
                    unique case (ir_ff)
                        CMD_CONTROL: begin
                            nxt_sr = ctrl_ff;
                            nxt_sr[PROCESSOR_ACCESS_FLAG_BIT] = processor_access_flag_ff;
                        end
                        CMD_DATA: nxt_sr = data_ff;
                        CMD_FAST: nxt_sr = fast_ff;
                        default: nxt_sr = 32'h00000000;
                    endcase
                end
                ST_SHIFT_IR: nxt_sr = shift_in(sr_ff, bits.tdi, 6'(IR_LEN));
                ST_SHIFT_DR: nxt_sr = shift_in(sr_ff, bits.tdi, dr_len(ir_ff));
                ST_UPD_IR: nxt_ir = sr_ff[IR_LEN-1:0];
                ST_UPD_DR: begin
                    unique case (ir_ff)
                        CMD_CONTROL: begin
                            nxt_ctrl = sr_ff & CTRL_WMASK;
                            if (!sr_ff[PROCESSOR_ACCESS_FLAG_BIT]) begin
                                nxt_exec = processor_access_flag_ff;
                                nxt_processor_access_flag = 1'b0;
                            end
                        end
                        CMD_DATA: nxt_data = sr_ff;
                        CMD_FAST: begin
                            nxt_fword = {1'b0, sr_ff[31:1]};
                            nxt_fvalid = 1'b1;
                            if (!sr_ff[0]) begin
                                nxt_processor_access_flag = 1'b0;
                            end
                        end
                        default: nxt_ir = ir_ff;
                    endcase
                end
                default: nxt_sr = sr_ff;
            endcase
        end
        if (force_rst) begin
            nxt_state = ST_RESET;
            nxt_ir = CMD_BYPASS;
        end
        if (i_cpu_access) begin
            nxt_processor_access_flag = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_RESET;
            ir_ff <= CMD_BYPASS;
            sr_ff <= 32'h00000000;
            ctrl_ff <= CTRL_RESET;
            data_ff <= 32'h00000000;
            fast_ff <= 32'h00000000;
            fword_ff <= 32'h00000000;
            processor_access_flag_ff <= 1'b0;
            exec_ff <= 1'b0;
            fvalid_ff <= 1'b0;
        end else if (i_ce) begin
            state_ff <= nxt_state;
            ir_ff <= nxt_ir;
            sr_ff <= nxt_sr;
            ctrl_ff <= nxt_ctrl;
            data_ff <= nxt_data;
            fast_ff <= nxt_fast;
            fword_ff <= nxt_fword;
            processor_access_flag_ff <= nxt_processor_access_flag;
            exec_ff <= nxt_exec;
            fvalid_ff <= nxt_fvalid;
        end
    end

    assign o_cpu_req = '{exec: exec_ff, instr: data_ff};
    assign o_fast_word = fword_ff;
    assign o_fast_valid = fvalid_ff;
    assign o_processor_access_flag = processor_access_flag_ff;

    ////////////////////////////////////////////////////////////////////////
    a_fast_flag_out: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        state_ff == ST_CAP_DR && ir_ff == CMD_FAST |-> tdo_c == processor_access_flag_ff)
        else $error("fast header did not show access flag");
    a_word_shift_lsb: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        step && i_ce && !force_rst && state_ff == ST_SHIFT_DR
            && ir_ff == CMD_DATA
        |=> sr_ff[31] == $past(bits.tdi) && sr_ff[30:0] == $past(sr_ff[31:1]))
        else $error("data shift not least bit first");
    a_processor_access_flag_set_wins: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        i_cpu_access && i_ce |=> processor_access_flag_ff)
        else $error("access request lost");
    a_exec_cause: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        step && i_ce && state_ff == ST_UPD_DR && ir_ff == CMD_CONTROL
            && !sr_ff[PROCESSOR_ACCESS_FLAG_BIT] && processor_access_flag_ff
        |=> o_cpu_req.exec && o_cpu_req.instr == $past(data_ff))
        else $error("instruction not released to CPU");
    a_exec_single: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        o_cpu_req.exec && i_ce |=> !o_cpu_req.exec)
        else $error("execute pulse longer than one cycle");
    a_fast_capture: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        step && i_ce && !force_rst && state_ff == ST_CAP_DR
            && ir_ff == CMD_FAST
        |=> sr_ff == $past(fast_ff) ##1 tdo_c == sr_ff[0])
        else $error("fast word not captured");
    a_force_tap_reset: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        force_rst && i_ce |=> state_ff == ST_RESET && ir_ff == CMD_BYPASS)
        else $error("resync did not reset the TAP");
endmodule // dtpos_top

//--- design/dtpos_pkg.sv
// Shared constants and types for the 2-wire debug TAP sequencer
// Summary of operation
// - During DR shift the device returns the selected register on data-out.
// - Fast transfer: access flag appears on data-out in last header clock.
// - After the access clock 32 bits follow, bit 0 first, last with mode-select high.
// - Host polls control with 0x0004C000 until access flag bit 18 reads 1.
// - Host writes instruction to data register, then 0x0000C000 executes it.
// - Then load, store to fast data register, no-op, and a fast read.
// - 4-phase: data pin high for 24 link clocks resets the TAP, ignoring all else.
// - Every serial field travels least significant bit first.
// - 4-phase: data-in, mode-select, data-out share the pin over 4 clocks.
// - 2-phase: only mode-select and data-in, two clocks, no data-out.
// - 2-phase: a packet executes only at the next packet's first clock.
package dtpos_pkg;
    localparam int IR_LEN = 5;
    localparam int DR_LEN = 32;
    localparam logic [5:0] LEN_BYPASS = 6'h01;
    localparam logic [5:0] LEN_WORD = 6'h20;
    // Command codes are arbitrary choices of this design
    localparam logic [4:0] CMD_DATA = 5'h03;
    localparam logic [4:0] CMD_CONTROL = 5'h04;
    localparam logic [4:0] CMD_FAST = 5'h05;
    localparam logic [4:0] CMD_BYPASS = 5'h1F;
    localparam logic [4:0] IR_CAPTURE = 5'h01;
    localparam int PROCESSOR_ACCESS_FLAG_BIT = 18;
    localparam logic [31:0] CTRL_WMASK = 32'h0000C000;
    localparam logic [31:0] CTRL_RESET = 32'h00000000;
    localparam logic [4:0] RESYNC_EDGES = 5'h18;

    typedef enum logic [1:0] {
        PH_TDI = 2'h0,
        PH_TMS = 2'h1,
        PH_TURN = 2'h3,
        PH_TDO = 2'h2
    } dtpos_phase_t;

    typedef enum logic [3:0] {
        ST_RESET = 4'h0,
        ST_IDLE = 4'h1,
        ST_SEL_DR = 4'h3,
        ST_CAP_DR = 4'h2,
        ST_SHIFT_DR = 4'h6,
        ST_EX1_DR = 4'h7,
        ST_UPD_DR = 4'h5,
        ST_PAUSE_DR = 4'h4,
        ST_EX2_DR = 4'hC,
        ST_SEL_IR = 4'hD,
        ST_CAP_IR = 4'hF,
        ST_SHIFT_IR = 4'hE,
        ST_EX1_IR = 4'hA,
        ST_UPD_IR = 4'hB,
        ST_PAUSE_IR = 4'h9,
        ST_EX2_IR = 4'h8
    } dtpos_tap_t;

    typedef struct packed {
        logic tms;
        logic tdi;
    } dtpos_bits_t;

    typedef struct packed {
        logic exec;
        logic [31:0] instr;
    } dtpos_cpu_req_t;
endpackage

//--- design/dtpos_phy.sv
// Two-wire pin demultiplexer: phases, deferred step, resync
`timescale 1ns/1ps
module dtpos_phy import dtpos_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_fall,
    input wire logic i_dat,
    input wire logic i_two_phase,
    input wire logic i_tdo,
    output logic o_step,
    output dtpos_bits_t o_bits,
    output logic o_force_reset,
    output logic o_pged,
    output logic o_pged_oe
);
    dtpos_phase_t phase_ff, nxt_phase;
    dtpos_bits_t hold_ff, nxt_hold;
    logic pend_ff, nxt_pend;
    logic tdo_ff, nxt_tdo;
    logic oe_ff, nxt_oe;
    logic out_ff, nxt_out;
    logic [4:0] cnt_ff, nxt_cnt;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_phase = phase_ff;
        nxt_hold = hold_ff;
        nxt_pend = pend_ff;
        nxt_tdo = tdo_ff;
        nxt_oe = oe_ff;
        nxt_out = out_ff;
        nxt_cnt = cnt_ff;
        o_step = 1'b0;
        o_bits = hold_ff;
        o_force_reset = 1'b0;
        if (i_fall) begin
            if (i_two_phase) begin
                nxt_oe = 1'b0;
                nxt_cnt = 5'h00;
                if (phase_ff == PH_TDI) begin
                    o_step = pend_ff;
                    nxt_pend = 1'b0;
                    nxt_hold.tdi = i_dat;
                    nxt_phase = PH_TMS;
                end else begin
                    nxt_hold.tms = i_dat;
                    nxt_pend = 1'b1;
                    nxt_phase = PH_TDI;
                end
            end else begin
                nxt_pend = 1'b0;
                nxt_cnt = i_dat ? 5'(cnt_ff + 5'h01) : 5'h00;
                unique case (phase_ff)
                    PH_TDI: begin
                        nxt_hold.tdi = i_dat;
                        nxt_phase = PH_TMS;
                    end
                    PH_TMS: begin
                        nxt_hold.tms = i_dat;
                        o_bits = '{tms: i_dat, tdi: hold_ff.tdi};
                        o_step = 1'b1;
                        nxt_tdo = i_tdo;
                        nxt_phase = PH_TURN;
                    end
                    PH_TURN: begin
                        nxt_oe = 1'b1;
                        nxt_out = tdo_ff;
                        nxt_phase = PH_TDO;
                    end
                    PH_TDO: begin
                        nxt_oe = 1'b0;
                        nxt_phase = PH_TDI;
                    end
                endcase
                if (i_dat && cnt_ff == 5'(RESYNC_EDGES - 5'h01)) begin
                    o_force_reset = 1'b1;
                    o_step = 1'b0;
                    nxt_phase = PH_TDI;
                    nxt_oe = 1'b0;
                    nxt_cnt = 5'h00;
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            phase_ff <= PH_TDI;
            hold_ff <= '0;
            pend_ff <= 1'b0;
            tdo_ff <= 1'b0;
            oe_ff <= 1'b0;
            out_ff <= 1'b0;
            cnt_ff <= 5'h00;
        end else if (i_ce) begin
            phase_ff <= nxt_phase;
            hold_ff <= nxt_hold;
            pend_ff <= nxt_pend;
            tdo_ff <= nxt_tdo;
            oe_ff <= nxt_oe;
            out_ff <= nxt_out;
            cnt_ff <= nxt_cnt;
        end
    end

    assign o_pged = out_ff;
    assign o_pged_oe = oe_ff;

    ////////////////////////////////////////////////////////////////////////
    a_oe_phase_window: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        o_pged_oe |-> phase_ff == PH_TDO)
        else $error("pin driven outside data-out phase");
    a_tdo_held_out: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        o_pged_oe |-> o_pged == tdo_ff)
        else $error("driven bit differs from captured data-out");
    a_two_phase_mute: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        $rose(o_pged_oe) |-> !$past(i_two_phase))
        else $error("pin driven in two-phase mode");
    a_deferred_step: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        o_step && i_two_phase |-> pend_ff && i_fall && phase_ff == PH_TDI)
        else $error("two-phase packet run too early");
    a_resync_reset: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        o_force_reset && i_ce |-> cnt_ff == 5'h17 && i_dat
            ##1 phase_ff == PH_TDI && !o_pged_oe && cnt_ff == 5'h00)
        else $error("resync fired at wrong count");
endmodule // dtpos_phy

//--- verification/dtpos_host_model.sv
// Programmer-side model that drives the 2-wire debug link
`timescale 1ns/1ps
module dtpos_host_model import dtpos_pkg::*; (
    input wire logic i_pged,
    input wire logic i_two_phase,
    output logic o_pgec,
    output logic o_pged,
    output logic o_pged_oe
);
    // Link clock rests low between frames
    initial begin
        o_pgec = 1'b0;
        o_pged = 1'b0;
        o_pged_oe = 1'b1;
    end
    // One link clock; the pin is read just before the falling edge
    task automatic link_clk(input logic d, input logic oe, output logic q);
        o_pged = d;
        o_pged_oe = oe;
        o_pgec = 1'b1;
        #80;
        q = i_pged;
        o_pgec = 1'b0;
        #80;
    endtask
    task automatic tck(input logic tdi, input logic tms, output logic tdo);
        logic q;
        link_clk(tdi, 1'b1, q);
        link_clk(tms, 1'b1, q);
        if (!i_two_phase) begin
            link_clk(tms, 1'b0, q);
            link_clk(tms, 1'b0, q);
        end
        tdo = q;
    endtask
    task automatic shift(input logic [31:0] din, input int n,
                         output logic [31:0] dout);
        logic b;
        dout = 32'h0;
        for (int i = 0; i < n; i++) begin
            tck(din[i], i == n - 1, b);
            dout[i] = b;
        end
    endtask
    task automatic set_mode(input logic [5:0] m, input int n);
        logic b;
        for (int i = 0; i < n; i++) tck(1'b0, m[i], b);
    endtask
    task automatic send_cmd(input logic [4:0] c, output logic [4:0] q);
        logic [31:0] d;
        set_mode(6'h03, 4);
        shift({27'h0, c}, IR_LEN, d);
        q = d[4:0];
        set_mode(6'h01, 2);
    endtask
    task automatic xfer(input logic [31:0] v, output logic [31:0] q);
        set_mode(6'h01, 3);
        shift(v, DR_LEN, q);
        set_mode(6'h01, 2);
    endtask
    task automatic fast(input logic [31:0] v, output logic acc,
                        output logic [31:0] q);
        logic b;
        tck(1'b0, 1'b1, b);
        tck(1'b0, 1'b0, b);
        tck(1'b0, 1'b0, acc);
        shift(v, DR_LEN, q);
        set_mode(6'h01, 2);
    endtask
    task automatic feed(input logic [31:0] ins, output logic ok);
        logic [4:0] ir;
        logic [31:0] q;
        ok = 1'b0;
        send_cmd(CMD_CONTROL, ir);
        for (int i = 0; i < 8 && !ok; i++) begin
            xfer(32'h0004C000, q);
            ok = q[PROCESSOR_ACCESS_FLAG_BIT];
        end
        send_cmd(CMD_DATA, ir);
        xfer(ins, q);
        send_cmd(CMD_CONTROL, ir);
        xfer(32'h0000C000, q);
    endtask
    task automatic mem_read(input logic [31:0] a, output logic ok,
                            output logic [31:0] q);
        logic [31:0] ins [6];
        logic [4:0] ir;
        logic f;
        logic acc;
        ins = '{32'h3C13FF20, {16'h3C08, a[31:16]}, {16'h3508, a[15:0]},
                32'h8D090000, 32'hAE690000, 32'h00000000};
        ok = 1'b1;
        acc = 1'b0;
        foreach (ins[i]) begin
            feed(ins[i], f);
            ok &= f;
        end
        send_cmd(CMD_FAST, ir);
        for (int i = 0; i < 8 && !acc; i++) fast(32'h0, acc, q);
        ok &= acc;
    endtask
    // Pin held high for 24 link clocks
    task automatic sync();
        logic b;
        repeat (24) link_clk(1'b1, 1'b1, b);
    endtask
endmodule // dtpos_host_model

//--- verification/debug_tap_pseudo_op_sequencer_bench.sv
// Self-checking bench for the 2-wire debug TAP sequencer
`timescale 1ns/1ps
module debug_tap_pseudo_op_sequencer_bench import dtpos_pkg::*; ;
    typedef struct packed {
        logic [4:0] cmd;
        logic [31:0] din;
        logic [31:0] dout;
    } dtpos_row_t;
    localparam dtpos_row_t ROWS [7] = '{
        '{CMD_CONTROL, 32'h0004C000, 32'h00000000},
        '{CMD_CONTROL, 32'h00000000, 32'h0000C000},
        '{CMD_CONTROL, 32'h0000C000, 32'h00000000},
        '{CMD_DATA, 32'h12345678, 32'h00000000},
        '{CMD_DATA, 32'hA5A5A5A5, 32'h12345678},
        '{CMD_BYPASS, 32'h0000000F, 32'h0000001E},
        '{5'h0A, 32'h80000001, 32'h00000002}};
    localparam logic [31:0] EXP_INS [6] = '{32'h3C13FF20, 32'h3C081D00,
        32'h350812A4, 32'h8D090000, 32'hAE690000, 32'h00000000};
    localparam logic [31:0] MEM_WORD = 32'h5A3C0F96;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic cpu_access = 1'b0;
    logic fast_wr = 1'b0;
    logic two_phase = 1'b0;
    logic cpu_on = 1'b0;
    logic host_pgec, host_d, host_oe, dev_d, dev_oe, wire_d;
    logic fast_valid, processor_access_flag;
    logic [31:0] fast_word, fast_last;
    dtpos_cpu_req_t cpu_req;
    logic [31:0] exec_q [$];
    int n_fail = 0;
    int tests_run = 0;
    int cycles = 0;
    int cnt = 0;
    int fast_seen = 0;
    int oe_2ph = 0;
    // Host wins a clash; an undriven pin shows the inverse level
    assign wire_d = host_oe ? host_d : (dev_oe ? dev_d : ~host_d);
    dtpos_top dtpos_top_inst (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1),
        .i_pgec(host_pgec), .i_pged(wire_d),
        .o_pged(dev_d), .o_pged_oe(dev_oe), .i_two_phase(two_phase),
        .i_cpu_access(cpu_access), .i_cpu_fast_wr(fast_wr),
        .i_cpu_fast_data(MEM_WORD), .o_cpu_req(cpu_req),
        .o_fast_word(fast_word), .o_fast_valid(fast_valid),
        .o_processor_access_flag(processor_access_flag));
    dtpos_host_model dtpos_host_model_inst (
        .i_pged(wire_d), .i_two_phase(two_phase),
        .o_pgec(host_pgec), .o_pged(host_d), .o_pged_oe(host_oe));
    always #10 i_clk = ~i_clk;
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // CPU stand-in: logs executed words, raises the flag, stores on sw
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        cpu_access <= cpu_on && cnt == 1;
        fast_wr <= cpu_req.exec === 1'b1 && cpu_req.instr === 32'hAE690000;
        if (cpu_req.exec === 1'b1) exec_q.push_back(cpu_req.instr);
        if (cnt > 0) cnt <= cnt - 1;
        else if (cpu_on && processor_access_flag === 1'b0) cnt <= 6;
        if (fast_valid === 1'b1) fast_seen <= fast_seen + 1;
        if (fast_valid === 1'b1) fast_last <= fast_word;
        if (two_phase && dev_oe === 1'b1) oe_2ph <= oe_2ph + 1;
        if (cycles == 90000) begin
            n_fail++;
            give_verdict();
        end
    end
    initial begin
        logic [4:0] ir;
        logic [31:0] q;
        logic acc;
        logic ok;
        int seen;
        repeat (5) @(posedge i_clk);
        check(cpu_req.instr, 32'h0);
        check({fast_word[31:2], fast_valid, processor_access_flag}, 32'h0);
        check({30'h0, cpu_req.exec, dev_oe}, 32'h0);
        repeat (5) @(posedge i_clk);
        #1 i_rst_n = 1'b1;
        repeat (8) @(posedge i_clk);
        #1;
        // TAP leaves reset in test-logic-reset; walk it to idle first
        dtpos_host_model_inst.set_mode(6'h1F, 6);
        foreach (ROWS[i]) begin
            dtpos_host_model_inst.send_cmd(ROWS[i].cmd, ir);
            check({27'h0, ir}, {27'h0, IR_CAPTURE});
            dtpos_host_model_inst.xfer(ROWS[i].din, q);
            check(q, ROWS[i].dout);
        end
        check(exec_q.size(), 32'h0);
        dtpos_host_model_inst.send_cmd(CMD_FAST, ir);
        dtpos_host_model_inst.fast(32'h2468ACE0, acc, q);
        check({31'h0, acc}, 32'h0);
        cpu_on = 1'b1;
        repeat (10) @(posedge i_clk);
        #1 cpu_on = 1'b0;
        dtpos_host_model_inst.fast(32'hF0E1D2C2, acc, q);
        check({31'h0, acc}, 32'h1);
        check(fast_last, 32'h7870E961);
        check({31'h0, processor_access_flag}, 32'h0);
        cpu_on = 1'b1;
        exec_q.delete();
        dtpos_host_model_inst.mem_read(32'h1D0012A4, ok, q);
        check({31'h0, ok}, 32'h1);
        check(q, MEM_WORD);
        check(exec_q.size(), 32'h6);
        foreach (exec_q[i]) check(exec_q[i], EXP_INS[i]);
        cpu_on = 1'b0;
        // Park inside Shift-DR one link clock off phase, then resync
        dtpos_host_model_inst.send_cmd(CMD_CONTROL, ir);
        dtpos_host_model_inst.set_mode(6'h01, 3);
        dtpos_host_model_inst.link_clk(1'b0, 1'b1, acc);
        dtpos_host_model_inst.sync();
        repeat (2) @(posedge i_clk);
        check({31'h0, dev_oe}, 32'h0);
        #1;
        dtpos_host_model_inst.set_mode(6'h00, 1);
        dtpos_host_model_inst.xfer(32'h0000000F, q);
        check(q, 32'h0000001E);
        two_phase = 1'b1;
        dtpos_host_model_inst.send_cmd(CMD_FAST, ir);
        seen = fast_seen;
        dtpos_host_model_inst.fast(32'h00000F0E, acc, q);
        repeat (6) @(posedge i_clk);
        check(fast_seen - seen, 32'h0);
        #1;
        dtpos_host_model_inst.tck(1'b0, 1'b0, acc);
        repeat (6) @(posedge i_clk);
        check(fast_seen - seen, 32'h1);
        check(fast_last, 32'h00000787);
        check(oe_2ph, 32'h0);
        give_verdict();
    end
endmodule // debug_tap_pseudo_op_sequencer_bench
